// [hw/lpm_irq_ctrl.sv]
// What this block does
// - Any taken interrupt wakes the system; return restores the earlier mode
// - Provide auxiliary clock from crystal, main CPU clock and subsystem clock
// - Crystal-select bit puts the crystal oscillator in high-frequency mode
// - After reset the main clock always comes from the digital oscillator
// - DC generator uses external resistor or one of eight internal steps
// - On acceptance the four power bits are pushed; handler may alter copy
// - Subsystem-off bit gates the subsystem clock off while set
// - DC generator runs while generator-off clear; stops only if unused
// - Crystal runs while off bit clear; stops only if unused; mask option
// - CPU-off bit stops the main clock while set and no request is pending
// - Generator-off never stops the oscillator feeding a running main/sub clock
// - Vectors sit at top of memory, each word a 16-bit handler address
// - All resets fetch the priority 15 vector; watchdog flag tells which
// - Pin non-maskable and oscillator fault share priority 14 vector
// - Watchdog interval at 10, channel 0 at 9, others and overflow at 8
// - Port 2 eight flags at priority 3, port 1 eight flags at 2
// - Unassigned register bits are absent: read zero, writes ignored
// - Enable register: watchdog bit 0, fault bit 1, pin bit 4, cleared
// - Flag register: watchdog 0, fault 1 set at clear, pin 4
// - Watchdog flag sets on overflow or bad key; cleared by power/pin reset
// - Pin flag sets on the configured edge of the reset/pin input
module lpm_irq_ctrl #(
  parameter logic XT_SHUTDOWN_EN = 1'b1
) (
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // AXI4-Lite slave
  input wire logic [lpm_irq_pkg::ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [lpm_irq_pkg::ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // CPU core
  input wire logic GIE_I,
  input wire logic CPU_LP_WE_I,
  input wire logic [3:0] CPU_LP_I,
  input wire logic IRQ_ACK_I,
  input wire logic RETURN_FROM_INTERRUPT_I,
  input wire logic [3:0] STACK_LP_I,
  output logic IRQ_REQ_O,
  output logic [15:0] VEC_ADDR_O,
  output logic [3:0] SAVED_LP_O,
  output logic [3:0] LP_BITS_O,
  // Event sources
  input wire logic PUC_I,
  input wire logic WDT_EVT_I,
  input wire logic OSC_FAULT_I,
  input wire logic NMI_PIN_I,
  input wire logic NMI_FALL_I,
  input wire logic CC0_REQ_I,
  input wire logic CC1_REQ_I,
  input wire logic CC2_REQ_I,
  input wire logic TOV_REQ_I,
  input wire logic [7:0] P1_FLAGS_I,
  input wire logic [7:0] P2_FLAGS_I,
  // Clock system controls
  output logic ACLK_EN_O,
  output logic MCLK_EN_O,
  output logic SUBSYSTEM_CLOCK_EN_O,
  output logic DCO_EN_O,
  output logic DCGEN_EN_O,
  output logic XTAL_EN_O,
  output logic XT_HF_O,
  output logic MCLK_FROM_XT_O,
  output logic SUBSYSTEM_CLOCK_FROM_XT_O,
  output logic [2:0] RSEL_O,
  output logic EXT_R_O
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic hit(input logic [lpm_irq_pkg::ADDR_W-1:0] a,
                               input logic [lpm_irq_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // ****************************************
  // State
  // ****************************************
  lpm_irq_pkg::lp_s lp_q;
  lpm_irq_pkg::lp_s saved_q;
  lpm_irq_pkg::clkctl_s clk_q;
  logic [7:0] ie_q;
  logic [7:0] ifg_q;
  logic boot_q;
  logic [2:0] pin_sync_q;
  logic pin_lvl_q;
  lpm_irq_pkg::bus_state_e wst_q;
  lpm_irq_pkg::bus_state_e rst_q;
  logic awready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [15:0] vec_q;
  logic mclk_q;
  logic subsystem_clock_q;
  logic aclk_q;
  logic dco_q;
  logic dcgen_q;
  logic xtal_q;

  // ****************************************
  // Pin synchroniser and edge
  // ****************************************
  wire pin_agree = (pin_sync_q[1] == pin_sync_q[2]);
  wire pin_new = pin_agree & (pin_sync_q[2] != pin_lvl_q);
  wire nmi_evt = pin_new & (NMI_FALL_I ? ~pin_sync_q[2] : pin_sync_q[2]);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_sync_q <= 3'h7;
      pin_lvl_q <= 1'b1;
    end else if (CE_I) begin
      pin_sync_q <= {pin_sync_q[1:0], NMI_PIN_I};
      if (pin_agree) begin
        pin_lvl_q <= pin_sync_q[2];
      end
    end
  end

  // ****************************************
  // Request arbitration
  // ****************************************
  wire nmi_req = (ifg_q[lpm_irq_pkg::BIT_NMI] & ie_q[lpm_irq_pkg::BIT_NMI]) |
                 (ifg_q[lpm_irq_pkg::BIT_OF] & ie_q[lpm_irq_pkg::BIT_OF]);
  wire wdt_req = GIE_I & ifg_q[lpm_irq_pkg::BIT_WDT] & ie_q[lpm_irq_pkg::BIT_WDT];
  wire cc0_req = GIE_I & CC0_REQ_I;
  wire tmr_req = GIE_I & (CC1_REQ_I | CC2_REQ_I | TOV_REQ_I);
  wire p2_req = GIE_I & (|P2_FLAGS_I);
  wire p1_req = GIE_I & (|P1_FLAGS_I);
  wire any_req = boot_q | nmi_req | wdt_req | cc0_req | tmr_req | p2_req | p1_req;
  wire [3:0] pri = boot_q ? lpm_irq_pkg::PRI_RESET :
                   nmi_req ? lpm_irq_pkg::PRI_NMI :
                   wdt_req ? lpm_irq_pkg::PRI_WDT :
                   cc0_req ? lpm_irq_pkg::PRI_CC0 :
                   tmr_req ? lpm_irq_pkg::PRI_TMR :
                   p2_req ? lpm_irq_pkg::PRI_P2 :
                   lpm_irq_pkg::PRI_P1;
  wire [15:0] vec_d = lpm_irq_pkg::VEC_BASE + {11'h000, pri, 1'b0};

  // ****************************************
  // Low-power bits
  // ****************************************
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      lp_q <= lpm_irq_pkg::LP_RST;
      saved_q <= lpm_irq_pkg::LP_RST;
      boot_q <= 1'b1;
    end else if (CE_I) begin
      if (PUC_I) begin
        lp_q <= lpm_irq_pkg::LP_RST;
        boot_q <= 1'b1;
      end else if (IRQ_ACK_I) begin
        saved_q <= lp_q;
        lp_q <= lpm_irq_pkg::LP_RST;
        if (pri == lpm_irq_pkg::PRI_RESET) begin
          boot_q <= 1'b0;
        end
      end else if (RETURN_FROM_INTERRUPT_I) begin
        lp_q <= STACK_LP_I;
      end else if (CPU_LP_WE_I) begin
        lp_q <= CPU_LP_I;
      end
    end
  end

  // ****************************************
  // Clock gating
  // ****************************************
  wire cpu_run = ~lp_q.cpu_off | any_req;
  wire sub_run = ~lp_q.sub_off;
  wire dco_need = (cpu_run & ~clk_q.msel[1]) | (sub_run & ~clk_q.ssel);
  wire xt_need = (cpu_run & clk_q.msel[1]) | (sub_run & clk_q.ssel);
  wire dco_run = dco_need | ~lp_q.gen_off;
  wire xt_run = xt_need | ~lp_q.osc_off | ~XT_SHUTDOWN_EN;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mclk_q <= 1'b1;
      subsystem_clock_q <= 1'b1;
      aclk_q <= 1'b1;
      dco_q <= 1'b1;
      dcgen_q <= 1'b1;
      xtal_q <= 1'b1;
    end else if (CE_I) begin
      mclk_q <= cpu_run;
      subsystem_clock_q <= sub_run;
      aclk_q <= xt_run;
      dco_q <= dco_run;
      dcgen_q <= dco_run;
      xtal_q <= xt_run;
    end
  end

  // ****************************************
  // AXI4-Lite decode
  // ****************************************
  wire wr_go = (wst_q == lpm_irq_pkg::BUS_IDLE) & AWVALID_I & WVALID_I;
  wire wr_take = (wst_q == lpm_irq_pkg::BUS_TAKE);
  wire wr_lane = wr_take & WSTRB_I[0];
  wire we_ie = wr_lane & hit(AWADDR_I, lpm_irq_pkg::ADDR_IE1);
  wire we_ifg = wr_lane & hit(AWADDR_I, lpm_irq_pkg::ADDR_INT_FLAG_1);
  wire we_clk = wr_lane & hit(AWADDR_I, lpm_irq_pkg::ADDR_CLKCTL);
  wire wr_map = hit(AWADDR_I, lpm_irq_pkg::ADDR_IE1) | hit(AWADDR_I, lpm_irq_pkg::ADDR_INT_FLAG_1) |
                hit(AWADDR_I, lpm_irq_pkg::ADDR_CLKCTL) |
                hit(AWADDR_I, lpm_irq_pkg::ADDR_LPSTAT);
  wire rd_go = (rst_q == lpm_irq_pkg::BUS_IDLE) & ARVALID_I;
  wire rd_take = (rst_q == lpm_irq_pkg::BUS_TAKE);
  wire [7:0] stat = {3'h0, any_req, lp_q};
  wire [7:0] rd_byte = hit(ARADDR_I, lpm_irq_pkg::ADDR_IE1) ? ie_q :
                       hit(ARADDR_I, lpm_irq_pkg::ADDR_INT_FLAG_1) ? ifg_q :
                       hit(ARADDR_I, lpm_irq_pkg::ADDR_CLKCTL) ? clk_q :
                       hit(ARADDR_I, lpm_irq_pkg::ADDR_LPSTAT) ? stat : 8'h00;
  wire rd_map = hit(ARADDR_I, lpm_irq_pkg::ADDR_IE1) | hit(ARADDR_I, lpm_irq_pkg::ADDR_INT_FLAG_1) |
                hit(ARADDR_I, lpm_irq_pkg::ADDR_CLKCTL) |
                hit(ARADDR_I, lpm_irq_pkg::ADDR_LPSTAT);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wst_q <= lpm_irq_pkg::BUS_IDLE;
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= lpm_irq_pkg::RESP_OKAY;
    end else if (CE_I) begin
      case (wst_q)
        lpm_irq_pkg::BUS_IDLE: begin
          if (wr_go) begin
            wst_q <= lpm_irq_pkg::BUS_TAKE;
            awready_q <= 1'b1;
          end
        end
        lpm_irq_pkg::BUS_TAKE: begin
          wst_q <= lpm_irq_pkg::BUS_RESP;
          awready_q <= 1'b0;
          bvalid_q <= 1'b1;
          bresp_q <= wr_map ? lpm_irq_pkg::RESP_OKAY : lpm_irq_pkg::RESP_SLVERR;
        end
        lpm_irq_pkg::BUS_RESP: begin
          if (BREADY_I) begin
            wst_q <= lpm_irq_pkg::BUS_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: begin
          wst_q <= lpm_irq_pkg::BUS_IDLE;
          awready_q <= 1'b0;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rst_q <= lpm_irq_pkg::BUS_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= lpm_irq_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (CE_I) begin
      case (rst_q)
        lpm_irq_pkg::BUS_IDLE: begin
          if (rd_go) begin
            rst_q <= lpm_irq_pkg::BUS_TAKE;
            arready_q <= 1'b1;
          end
        end
        lpm_irq_pkg::BUS_TAKE: begin
          rst_q <= lpm_irq_pkg::BUS_RESP;
          arready_q <= 1'b0;
          rvalid_q <= 1'b1;
          rdata_q <= {24'h00_0000, rd_byte};
          rresp_q <= rd_map ? lpm_irq_pkg::RESP_OKAY : lpm_irq_pkg::RESP_SLVERR;
        end
        lpm_irq_pkg::BUS_RESP: begin
          if (RREADY_I) begin
            rst_q <= lpm_irq_pkg::BUS_IDLE;
            rvalid_q <= 1'b0;
          end
        end
        default: begin
          rst_q <= lpm_irq_pkg::BUS_IDLE;
          arready_q <= 1'b0;
          rvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Enable, flag and clock control registers
  // ****************************************
  wire [7:0] ifg_sw = we_ifg ? (WDATA_I[7:0] & lpm_irq_pkg::IE1_MASK) : ifg_q;
  wire [7:0] ifg_set = ({7'h00, WDT_EVT_I} << lpm_irq_pkg::BIT_WDT) |
                       ({7'h00, OSC_FAULT_I} << lpm_irq_pkg::BIT_OF) |
                       ({7'h00, nmi_evt} << lpm_irq_pkg::BIT_NMI);
  wire [7:0] ifg_puc = (ifg_q & (8'h01 << lpm_irq_pkg::BIT_WDT)) | lpm_irq_pkg::INT_FLAG_1_PUC;
  wire [7:0] ifg_d = (PUC_I ? ifg_puc : ifg_sw) | ifg_set;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ie_q <= lpm_irq_pkg::IE1_RST;
      ifg_q <= lpm_irq_pkg::INT_FLAG_1_RST;
      clk_q <= lpm_irq_pkg::CLKCTL_RST;
    end else if (CE_I) begin
      ifg_q <= ifg_d;
      if (PUC_I) begin
        ie_q <= lpm_irq_pkg::IE1_RST;
        clk_q <= lpm_irq_pkg::CLKCTL_RST;
      end else begin
        if (we_ie) begin
          ie_q <= WDATA_I[7:0] & lpm_irq_pkg::IE1_MASK;
        end
        if (we_clk) begin
          clk_q <= WDATA_I[7:0];
        end
      end
    end
  end

  // ****************************************
  // Vector output
  // ****************************************
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      irq_q <= 1'b0;
      vec_q <= lpm_irq_pkg::VEC_BASE;
    end else if (CE_I) begin
      irq_q <= any_req;
      vec_q <= vec_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AWREADY_O = awready_q;
  assign WREADY_O = awready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RRESP_O = rresp_q;
  assign RDATA_O = rdata_q;
  assign IRQ_REQ_O = irq_q;
  assign VEC_ADDR_O = vec_q;
  assign SAVED_LP_O = saved_q;
  assign LP_BITS_O = lp_q;
  assign ACLK_EN_O = aclk_q;
  assign MCLK_EN_O = mclk_q;
  assign SUBSYSTEM_CLOCK_EN_O = subsystem_clock_q;
  assign DCO_EN_O = dco_q;
  assign DCGEN_EN_O = dcgen_q;
  assign XTAL_EN_O = xtal_q;
  assign XT_HF_O = clk_q.xt_hf;
  assign MCLK_FROM_XT_O = clk_q.msel[1];
  assign SUBSYSTEM_CLOCK_FROM_XT_O = clk_q.ssel;
  assign RSEL_O = clk_q.rsel;
  assign EXT_R_O = clk_q.ext_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  AST_WAKE: assert property (CE_I && IRQ_ACK_I && !PUC_I |=> lp_q == 4'h0)
    else $error("power bits not cleared on interrupt");
  AST_RESTORE: assert property (CE_I && RETURN_FROM_INTERRUPT_I && !IRQ_ACK_I && !PUC_I
                                |=> lp_q == $past(STACK_LP_I))
    else $error("power bits not restored on return");
  AST_PUSH: assert property (CE_I && IRQ_ACK_I && !PUC_I
                             |=> SAVED_LP_O == $past(lp_q))
    else $error("pushed copy differs from power bits");
  AST_SUBSYSTEM_CLOCK: assert property (CE_I |=> SUBSYSTEM_CLOCK_EN_O == !$past(lp_q.sub_off))
    else $error("subsystem clock enable wrong");
  AST_DCO_HOLD: assert property (CE_I && !lp_q.cpu_off && !clk_q.msel[1]
                                 |=> DCO_EN_O && DCGEN_EN_O)
    else $error("oscillator stopped while feeding main clock");
  AST_XTAL: assert property (CE_I && !lp_q.osc_off |=> XTAL_EN_O)
    else $error("crystal stopped with off bit clear");
  AST_MCLK: assert property (CE_I && lp_q.cpu_off && !any_req |=> !MCLK_EN_O)
    else $error("main clock runs with cpu off set");
  AST_NMI_VEC: assert property (CE_I && nmi_req && !boot_q
                                |=> VEC_ADDR_O == lpm_irq_pkg::VEC_NMI)
    else $error("non-maskable vector wrong");
  AST_OSC_FAULT_FLAG: assert property (CE_I && OSC_FAULT_I |=> ifg_q[lpm_irq_pkg::BIT_OF])
    else $error("fault flag not set");
  AST_IE_PUC: assert property (CE_I && PUC_I |=> ie_q == 8'h00)
    else $error("enables not cleared by clear");

endmodule : lpm_irq_ctrl

// [inc/lpm_irq_pkg.sv]
package lpm_irq_pkg;

  // ****************************************
  // Register map (index, byte address)
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] IDX_IE1 = 5'h00;
  localparam logic [ADDR_W-1:0] IDX_INT_FLAG_1 = 5'h02;
  localparam logic [ADDR_W-1:0] IDX_CLKCTL = 5'h04;
  localparam logic [ADDR_W-1:0] IDX_LPSTAT = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_IE1 = IDX_IE1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_INT_FLAG_1 = IDX_INT_FLAG_1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_CLKCTL = IDX_CLKCTL << 2;
  localparam logic [ADDR_W-1:0] ADDR_LPSTAT = IDX_LPSTAT << 2;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned BIT_WDT = 0;
  localparam int unsigned BIT_OF = 1;
  localparam int unsigned BIT_NMI = 4;
  localparam int unsigned BIT_PEND = 4;
  localparam logic [7:0] IE1_MASK = 8'h13;
  localparam logic [7:0] IE1_RST = 8'h00;
  localparam logic [7:0] INT_FLAG_1_PUC = 8'h02;
  localparam logic [7:0] INT_FLAG_1_RST = 8'h02;
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Vector table
  // ****************************************
  localparam logic [15:0] VEC_BASE = 16'hffe0;
  localparam logic [3:0] PRI_RESET = 4'hf;
  localparam logic [3:0] PRI_NMI = 4'he;
  localparam logic [3:0] PRI_WDT = 4'ha;
  localparam logic [3:0] PRI_CC0 = 4'h9;
  localparam logic [3:0] PRI_TMR = 4'h8;
  localparam logic [3:0] PRI_P2 = 4'h3;
  localparam logic [3:0] PRI_P1 = 4'h2;
  localparam logic [15:0] VEC_NMI = 16'hfffc;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic gen_off;
    logic sub_off;
    logic osc_off;
    logic cpu_off;
  } lp_s;
  localparam lp_s LP_RST = 4'h0;

  typedef struct packed {
    logic [2:0] rsel;
    logic ext_r;
    logic xt_hf;
    logic ssel;
    logic [1:0] msel;
  } clkctl_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_TAKE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_e;

endpackage : lpm_irq_pkg

// [testbench/cpu_core_model.sv]
module cpu_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic take_i,
  input wire logic [3:0] slow_i,
  input wire logic [3:0] edit_i,
  // Controller side
  input wire logic irq_req_i,
  input wire logic [3:0] saved_lp_i,
  output logic ack_o,
  output logic return_from_interrupt_o,
  output logic [3:0] stack_lp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [3:0] wait_q;
  // ****************************************
  // Take request, run handler, return
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      ack_o <= 1'b0;
      return_from_interrupt_o <= 1'b0;
      stack_lp_o <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      return_from_interrupt_o <= 1'b0;
      if (!busy_q && take_i && irq_req_i && !ack_o) begin
        wait_q <= (wait_q == slow_i) ? 4'h0 : wait_q + 4'h1;
        busy_q <= (wait_q == slow_i);
        ack_o <= (wait_q == slow_i);
      end else if (busy_q) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == 4'h3) begin
          // Handler edits the stacked power bits before return
          stack_lp_o <= saved_lp_i ^ edit_i;
          return_from_interrupt_o <= 1'b1;
          busy_q <= 1'b0;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule : cpu_core_model

// [testbench/lpm_irq_ctrl_bench.sv]
module lpm_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, gie, lp_we, ack, return_from_interrupt, power_up_clear;
  logic wdt_evt, osc_fault, nmi_pin, nmi_fall, cc0, cc1, cc2, tov, take;
  logic awready, wready, bvalid, arready, rvalid, irq_req;
  logic mclk_en, subsystem_clock_en, dco_en, xtal_en, mclk_xt;
  logic aclk_en, dcgen_en, xt_hf, subsystem_clock_xt, ext_r, ce;
  logic [2:0] rsel;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] cpu_lp, stack_lp, saved_lp, lp_bits, slow, edit;
  logic [7:0] p1, p2;
  logic [15:0] vec;
  int fails = 0;
  int tests_run = 0;
  // ****************************************
  // Clock, design, partner
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  lpm_irq_ctrl dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .GIE_I(gie), .CPU_LP_WE_I(lp_we), .CPU_LP_I(cpu_lp),
    .IRQ_ACK_I(ack), .RETURN_FROM_INTERRUPT_I(return_from_interrupt), .STACK_LP_I(stack_lp), .IRQ_REQ_O(irq_req),
    .VEC_ADDR_O(vec), .SAVED_LP_O(saved_lp), .LP_BITS_O(lp_bits), .PUC_I(power_up_clear),
    .WDT_EVT_I(wdt_evt), .OSC_FAULT_I(osc_fault), .NMI_PIN_I(nmi_pin),
    .NMI_FALL_I(nmi_fall), .CC0_REQ_I(cc0), .CC1_REQ_I(cc1), .CC2_REQ_I(cc2),
    .TOV_REQ_I(tov), .P1_FLAGS_I(p1), .P2_FLAGS_I(p2), .ACLK_EN_O(aclk_en),
    .MCLK_EN_O(mclk_en), .SUBSYSTEM_CLOCK_EN_O(subsystem_clock_en), .DCO_EN_O(dco_en), .DCGEN_EN_O(dcgen_en),
    .XTAL_EN_O(xtal_en), .XT_HF_O(xt_hf), .MCLK_FROM_XT_O(mclk_xt),
    .SUBSYSTEM_CLOCK_FROM_XT_O(subsystem_clock_xt), .RSEL_O(rsel), .EXT_R_O(ext_r));
  cpu_core_model cpu (.clk_i(clk), .rst_i(rst), .take_i(take), .slow_i(slow),
    .edit_i(edit), .irq_req_i(irq_req), .saved_lp_i(saved_lp), .ack_o(ack),
    .return_from_interrupt_o(return_from_interrupt), .stack_lp_o(stack_lp));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(posedge clk);
    while (s !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) fails++;
  endtask : wait_hi
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_hi(awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(bvalid);
    bready <= 1'b0;
    tick(1);
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    tick(1);
  endtask : axi_rd
  task automatic set_lp(input logic [3:0] v);
    cpu_lp <= v;
    lp_we <= 1'b1;
    tick(1);
    lp_we <= 1'b0;
    tick(3);
  endtask : set_lp
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    tick(2);
    chk("boot vector", {16'h0, 16'hfffe}, {16'h0, vec});
    chk("main from osc", 32'h0, {31'h0, mclk_xt});
    axi_rd(lpm_irq_pkg::ADDR_IE1);
    chk("enable reset", 32'h0, rd);
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("flag reset", 32'h2, rd);
    axi_rd(5'h0c);
    chk("unmapped resp", {30'h0, lpm_irq_pkg::RESP_SLVERR}, {30'h0, rs});
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'hff);
    axi_rd(lpm_irq_pkg::ADDR_IE1);
    chk("enable bits", 32'h13, rd);
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'h0);
    take <= 1'b1;
    wait_hi(ack);
    take <= 1'b0;
    tick(8);
    chk("idle request", 32'h0, {31'h0, irq_req});
    $display("test reset done");
  endtask : t_reset
  task automatic t_prio;
    gie <= 1'b1;
    cc0 <= 1'b1;
    tov <= 1'b1;
    p1 <= 8'h80;
    p2 <= 8'h40;
    tick(3);
    chk("vector cc0", {16'h0, 16'hfff2}, {16'h0, vec});
    cc0 <= 1'b0;
    tick(3);
    chk("vector timer", {16'h0, 16'hfff0}, {16'h0, vec});
    tov <= 1'b0;
    tick(3);
    chk("vector port2", {16'h0, 16'hffe6}, {16'h0, vec});
    p2 <= 8'h0;
    tick(3);
    chk("vector port1", {16'h0, 16'hffe4}, {16'h0, vec});
    chk("port1 request", 32'h1, {31'h0, irq_req});
    p1 <= 8'h0;
    gie <= 1'b0;
    cc2 <= 1'b1;
    tick(3);
    chk("masked request", 32'h0, {31'h0, irq_req});
    cc2 <= 1'b0;
    $display("test priority done");
  endtask : t_prio
  task automatic t_events;
    wdt_evt <= 1'b1;
    tick(1);
    wdt_evt <= 1'b0;
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("watchdog flag", 32'h3, rd);
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'h1);
    gie <= 1'b1;
    tick(3);
    chk("vector watchdog", {16'h0, 16'hfff4}, {16'h0, vec});
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'h3);
    tick(3);
    chk("vector fault", {16'h0, 16'hfffc}, {16'h0, vec});
    nmi_pin <= 1'b0;
    tick(8);
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("pin flag", 32'h13, rd);
    axi_wr(lpm_irq_pkg::ADDR_INT_FLAG_1, 32'h0);
    osc_fault <= 1'b1;
    tick(1);
    osc_fault <= 1'b0;
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("fault flag", 32'h2, rd);
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'h0);
    gie <= 1'b0;
    $display("test events done");
  endtask : t_events
  task automatic t_power;
    set_lp(4'h5);
    chk("cpu clock off", 32'h0, {31'h0, mclk_en});
    chk("sub clock off", 32'h0, {31'h0, subsystem_clock_en});
    chk("gen kept", 32'h1, {31'h0, dco_en});
    set_lp(4'hd);
    chk("gen stopped", 32'h0, {31'h0, dco_en});
    chk("gen core stopped", 32'h0, {31'h0, dcgen_en});
    chk("crystal kept", 32'h1, {31'h0, xtal_en});
    set_lp(4'hf);
    chk("crystal stopped", 32'h0, {31'h0, xtal_en});
    set_lp(4'h8);
    chk("osc feeds cpu", 32'h1, {31'h0, dco_en});
    set_lp(4'h1);
    gie <= 1'b1;
    cc0 <= 1'b1;
    tick(3);
    chk("wake clock", 32'h1, {31'h0, mclk_en});
    edit <= 4'h3;
    slow <= 4'h2;
    take <= 1'b1;
    wait_hi(ack);
    take <= 1'b0;
    cc0 <= 1'b0;
    tick(1);
    chk("saved bits", 32'h1, {28'h0, saved_lp});
    chk("active bits", 32'h0, {28'h0, lp_bits});
    tick(4);
    chk("restored bits", 32'h2, {28'h0, lp_bits});
    gie <= 1'b0;
    $display("test power done");
  endtask : t_power
  task automatic t_clkctl;
    axi_wr(lpm_irq_pkg::ADDR_CLKCTL, 32'h3e);
    axi_rd(lpm_irq_pkg::ADDR_CLKCTL);
    chk("clock control", 32'h3e, rd);
    chk("resistor step", 32'h1, {29'h0, rsel});
    chk("external resistor", 32'h1, {31'h0, ext_r});
    chk("crystal high freq", 32'h1, {31'h0, xt_hf});
    chk("main from crystal", 32'h1, {31'h0, mclk_xt});
    chk("sub from crystal", 32'h1, {31'h0, subsystem_clock_xt});
    chk("crystal feeds cpu", 32'h1, {31'h0, xtal_en});
    chk("auxiliary clock", 32'h1, {31'h0, aclk_en});
    axi_rd(lpm_irq_pkg::ADDR_LPSTAT);
    chk("power status", 32'h2, rd);
    ce <= 1'b0;
    wdt_evt <= 1'b1;
    tick(2);
    wdt_evt <= 1'b0;
    ce <= 1'b1;
    nmi_fall <= 1'b0;
    nmi_pin <= 1'b1;
    tick(8);
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("frozen and rising flags", 32'h12, rd);
    axi_wr(lpm_irq_pkg::ADDR_IE1, 32'h10);
    power_up_clear <= 1'b1;
    tick(1);
    power_up_clear <= 1'b0;
    tick(2);
    chk("clear boot vector", {16'h0, 16'hfffe}, {16'h0, vec});
    chk("clear main select", 32'h0, {31'h0, mclk_xt});
    axi_rd(lpm_irq_pkg::ADDR_IE1);
    chk("clear enables", 32'h0, rd);
    axi_rd(lpm_irq_pkg::ADDR_INT_FLAG_1);
    chk("clear flags", 32'h2, rd);
    $display("test clock control done");
  endtask : t_clkctl
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    {rst, nmi_pin, nmi_fall, ce} = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, gie, lp_we, power_up_clear} = 8'h0;
    {wdt_evt, osc_fault, cc0, cc1, cc2, tov, take} = 7'h0;
    {awaddr, araddr, wdata, cpu_lp, p1, p2, slow, edit} = '0;
    tick(2);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_events();
    t_power();
    t_clkctl();
    report_and_stop();
  end
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule : lpm_irq_ctrl_bench
